// *** dmxdc_pkg.sv ***
// Package of constants and carrier types for the drum position control block
package dmxdc_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_IRQ     = 8'h08;
  localparam logic [7:0] ADDR_MASK    = 8'h0C;
  localparam logic [7:0] ADDR_CH_LO   = 8'h10;
  localparam logic [7:0] ADDR_CH_HI   = 8'h14;
  localparam logic [7:0] ADDR_POS     = 8'h18;
  localparam logic [7:0] ADDR_TOP     = 8'h1C;
  localparam logic [7:0] ADDR_BOT     = 8'h20;
  localparam logic [7:0] ADDR_RANGE   = 8'h24;
  localparam logic [7:0] ADDR_SAVED   = 8'h28;

  // ---------------------------------------------------------------
  // Control field positions and reset values
  // ---------------------------------------------------------------
  localparam int         CTRL_ADDR_LSB  = 0;
  localparam int         CTRL_SAVED_BIT = 16;
  localparam logic [8:0] START_ADDR_RST = 9'h001;
  localparam logic [8:0] START_ADDR_MIN = 9'h001;
  localparam logic [8:0] START_ADDR_MAX = 9'h1FA;

  // ---------------------------------------------------------------
  // Interrupt event bit positions
  // ---------------------------------------------------------------
  localparam int IRQ_TOP_SET   = 0;
  localparam int IRQ_BOT_SET   = 1;
  localparam int IRQ_SAVED     = 2;
  localparam int IRQ_HARD_LIM  = 3;
  localparam int IRQ_W         = 4;

  // ---------------------------------------------------------------
  // Channel level thresholds (of 255)
  // ---------------------------------------------------------------
  localparam logic [7:0] RUN_LO    = 8'h80;  // 50 %
  localparam logic [7:0] RUN_HI    = 8'h8C;  // 55 %
  localparam logic [7:0] MAN_MIN   = 8'h06;  // 2 %

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ         = 50_000_000;
  localparam int MAN_DELAY_S    = 3;
  localparam int MAN_DELAY_CYC  = MAN_DELAY_S * CLK_HZ;
  localparam int SAVE_DELAY_MS  = 100;
  localparam int SAVE_DELAY_CYC = SAVE_DELAY_MS * (CLK_HZ / 1000);

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [4:0]
  {
    ST_IDLE = 5'b00001,
    ST_POS  = 5'b00010,
    ST_WAIT = 5'b00100,
    ST_MAN  = 5'b01000,
    ST_STOP = 5'b10000
  } dmxdc_state_t;

  typedef struct packed
  {
    logic [7:0] pos_hi;
    logic [7:0] pos_lo;
    logic [7:0] speed;
    logic [7:0] safety;
    logic [7:0] man_up;
    logic [7:0] man_dn;
  } dmxdc_chan_t;

  typedef struct packed
  {
    logic       run;
    logic       dir_up;
    logic [7:0] speed;
  } dmxdc_motor_t;

endpackage

// *** dmxdc_chan_capture.sv ***
// Captures the six control channels starting at the start address
`timescale 1ns/100ps
module dmxdc_chan_capture
(
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic [8:0]          start_addr,
  input  wire logic                slot_valid,
  input  wire logic [8:0]          slot_num,
  input  wire logic [7:0]          slot_data,
  output dmxdc_pkg::dmxdc_chan_t   chan
);

  typedef struct packed
  {
    dmxdc_pkg::dmxdc_chan_t chan;
  } dmxdc_cap_state_t;

  dmxdc_cap_state_t state_reg;
  dmxdc_cap_state_t state_next;
  logic [9:0]       offset;

  // Slot index is relative to the start address; six channels used
  assign offset = {1'b0, slot_num} - {1'b0, start_addr};

  always_comb
  begin
    state_next = state_reg;
    if (slot_valid && slot_num >= start_addr)
    begin
      case (offset)
        10'h000: state_next.chan.pos_hi = slot_data;
        10'h001: state_next.chan.pos_lo = slot_data;
        10'h002: state_next.chan.speed  = slot_data;
        10'h003: state_next.chan.safety = slot_data;
        10'h004: state_next.chan.man_up = slot_data;
        10'h005: state_next.chan.man_dn = slot_data;
        default: state_next = state_reg;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign chan = state_reg.chan;

  a_capture_first: assert property (@(posedge core_clk) disable iff (!rst_n)
    slot_valid && slot_num == start_addr |=> chan.pos_hi == $past(slot_data))
    else $error("first channel not captured at start address");

endmodule

// *** dmxdc_delay_timer.sv ***
// Counts a programmable delay after its enable rises
`timescale 1ns/100ps
module dmxdc_delay_timer
#(
  parameter int CYCLES = 150_000_000
)
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic enable,
  output logic      done
);

  typedef struct packed
  {
    logic [31:0] count;
    logic        done;
  } dmxdc_tmr_state_t;

  dmxdc_tmr_state_t state_reg;
  dmxdc_tmr_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    if (!enable)
    begin
      state_next.count = '0;
      state_next.done  = 1'b0;
    end
    else if (state_reg.count >= 32'(CYCLES - 1))
      state_next.done = 1'b1;
    else
      state_next.count = state_reg.count + 32'h1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign done = state_reg.done;

  a_timer_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    !enable |=> !done)
    else $error("timer done without enable");

endmodule

// *** dmxdc_drum_ctrl.sv ***
// Top of the drum position control block: channel decode, motion, limits, APB
//
// Overview of operation
// - First channel sits at start address 1 to 506; five more follow.
// - Target position is channel one high byte, channel two low byte.
// - Channel three level caps positioning speed.
// - Channel three at zero holds the motor still while positioning.
// - Running allowed only while channel four is 50 to 55 percent.
// - Outside that window: stop, clear errors, later store position.
// - Without stored position, soft top is invalid after power-on.
// - Channel five at two percent or more drives up to hard top.
// - Upward manual speed follows channel five level.
// - Channel six at two percent or more drives down to hard bottom.
// - Downward manual speed follows channel six level.
// - Manual travel starts three seconds after its channel activates.
// - Manual channel back to zero returns to target if bottom valid, speed nonzero.
// - Soft top must be set before soft bottom.
// - Travel range is encoder pulses between soft limits.
`timescale 1ns/100ps
module dmxdc_drum_ctrl
#(
  parameter int MAN_DELAY  = dmxdc_pkg::MAN_DELAY_CYC,
  parameter int SAVE_DELAY = dmxdc_pkg::SAVE_DELAY_CYC
)
(
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 slot_valid,
  input  wire logic [8:0]           slot_num,
  input  wire logic [7:0]           slot_data,
  input  wire logic [31:0]          enc_count,
  input  wire logic                 hard_top,
  input  wire logic                 hard_bot,
  output dmxdc_pkg::dmxdc_motor_t   motor,
  output logic                      save_req,
  output logic                      err_clear,
  output logic                      irq
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed
  {
    dmxdc_pkg::dmxdc_state_t fsm;
    dmxdc_pkg::dmxdc_motor_t motor;
    logic [8:0]              start_addr;
    logic                    saved_flag;
    logic                    top_valid;
    logic                    bot_valid;
    logic [31:0]             top_cnt;
    logic [31:0]             bot_cnt;
    logic [31:0]             range;
    logic [31:0]             saved_pos;
    logic                    man_up_q;
    logic                    man_dn_q;
    logic                    save_done;
    logic                    save_req;
    logic                    err_clear;
    logic [dmxdc_pkg::IRQ_W-1:0] irq_stat;
    logic [dmxdc_pkg::IRQ_W-1:0] irq_mask;
    logic [31:0]             prdata;
  } dmxdc_top_state_t;

  dmxdc_top_state_t       state_reg;
  dmxdc_top_state_t       state_next;
  dmxdc_pkg::dmxdc_chan_t chan;
  logic                   run_ok;
  logic                   man_up;
  logic                   man_dn;
  logic                   man_any;
  logic                   man_go;
  logic                   save_go;
  logic [15:0]            target;
  logic [47:0]            tgt_prod;
  logic [31:0]            tgt_cnt;
  logic                   apb_wr;
  logic                   apb_rd;
  logic [dmxdc_pkg::IRQ_W-1:0] ev;

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  dmxdc_chan_capture u_cap
  (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .start_addr (state_reg.start_addr),
    .slot_valid (slot_valid),
    .slot_num   (slot_num),
    .slot_data  (slot_data),
    .chan       (chan)
  );

  dmxdc_delay_timer #(.CYCLES(MAN_DELAY)) u_man_tmr
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .enable   (man_any && run_ok),
    .done     (man_go)
  );

  // Position is stored only after the stop has lasted a while
  dmxdc_delay_timer #(.CYCLES(SAVE_DELAY)) u_save_tmr
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .enable   (!run_ok),
    .done     (save_go)
  );

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  assign run_ok  = chan.safety >= dmxdc_pkg::RUN_LO && chan.safety <= dmxdc_pkg::RUN_HI;
  assign man_up  = chan.man_up >= dmxdc_pkg::MAN_MIN;
  assign man_dn  = chan.man_dn >= dmxdc_pkg::MAN_MIN;
  assign man_any = man_up || man_dn;
  assign target  = {chan.pos_hi, chan.pos_lo};
  // Target 0 maps to bottom; span scaled by target/65536, so FFFF stops one count below top for spans under 65536
  assign tgt_prod = {16'h0, state_reg.range} * {32'h0, target};
  assign tgt_cnt  = state_reg.bot_cnt + tgt_prod[47:16];

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    state_next            = state_reg;
    state_next.man_up_q   = man_up;
    state_next.man_dn_q   = man_dn;
    state_next.save_req   = 1'b0;
    state_next.err_clear  = 1'b0;
    state_next.motor.run  = 1'b0;
    ev                    = '0;

    case (state_reg.fsm)
      dmxdc_pkg::ST_IDLE:
      begin
        if (man_any)
          state_next.fsm = dmxdc_pkg::ST_WAIT;
        else if (state_reg.top_valid && state_reg.bot_valid)
          state_next.fsm = dmxdc_pkg::ST_POS;
      end
      dmxdc_pkg::ST_POS:
      begin
        if (man_any)
          state_next.fsm = dmxdc_pkg::ST_WAIT;
        else if (chan.speed != 8'h00 && enc_count != tgt_cnt)
        begin
          state_next.motor.run    = 1'b1;
          state_next.motor.dir_up = enc_count < tgt_cnt;
          state_next.motor.speed  = chan.speed;
        end
      end
      dmxdc_pkg::ST_WAIT:
      begin
        if (!man_any)
          state_next.fsm = dmxdc_pkg::ST_IDLE;
        else if (man_go)
          state_next.fsm = dmxdc_pkg::ST_MAN;
      end
      dmxdc_pkg::ST_MAN:
      begin
        state_next.motor.run    = man_any;
        state_next.motor.dir_up = man_up;
        state_next.motor.speed  = man_up ? chan.man_up : chan.man_dn;
        if (!man_any)
          state_next.fsm = (state_reg.bot_valid && chan.speed != 8'h00) ?
                           dmxdc_pkg::ST_POS : dmxdc_pkg::ST_IDLE;
      end
      dmxdc_pkg::ST_STOP:
      begin
        if (run_ok)
          state_next.fsm = dmxdc_pkg::ST_IDLE;
      end
      default: state_next.fsm = dmxdc_pkg::ST_IDLE;
    endcase

    // Soft limits learned when the manual fader drops out
    if (state_reg.fsm == dmxdc_pkg::ST_MAN && state_reg.man_up_q && !man_up)
    begin
      state_next.top_cnt   = enc_count;
      state_next.top_valid = 1'b1;
      state_next.bot_valid = 1'b0;
      ev[dmxdc_pkg::IRQ_TOP_SET] = 1'b1;
    end
    if (state_reg.fsm == dmxdc_pkg::ST_MAN && state_reg.man_dn_q && !man_dn
        && state_reg.top_valid)
    begin
      state_next.bot_cnt   = enc_count;
      state_next.bot_valid = 1'b1;
      state_next.range     = state_reg.top_cnt - enc_count;
      ev[dmxdc_pkg::IRQ_BOT_SET] = 1'b1;
    end

    // Hard limits override every source of motion
    if ((hard_top && state_next.motor.dir_up) || (hard_bot && !state_next.motor.dir_up))
    begin
      if (state_next.motor.run)
        ev[dmxdc_pkg::IRQ_HARD_LIM] = 1'b1;
      state_next.motor.run = 1'b0;
    end

    if (!run_ok)
    begin
      state_next.fsm       = dmxdc_pkg::ST_STOP;
      state_next.motor.run = 1'b0;
      state_next.err_clear = 1'b1;
      if (save_go && !state_reg.save_done)
      begin
        state_next.save_req   = 1'b1;
        state_next.save_done  = 1'b1;
        state_next.saved_flag = 1'b1;
        state_next.saved_pos  = enc_count;
        ev[dmxdc_pkg::IRQ_SAVED] = 1'b1;
      end
    end
    else
      state_next.save_done = 1'b0;

    // APB writes
    if (apb_wr)
    begin
      case (paddr)
        dmxdc_pkg::ADDR_CTRL:
        begin
          if (pwdata[8:0] >= dmxdc_pkg::START_ADDR_MIN && pwdata[8:0] <= dmxdc_pkg::START_ADDR_MAX)
            state_next.start_addr = pwdata[8:0];
          // Power-on restore: software reports whether a position survived
          state_next.saved_flag = pwdata[dmxdc_pkg::CTRL_SAVED_BIT] || ev[dmxdc_pkg::IRQ_SAVED];
          if (!pwdata[dmxdc_pkg::CTRL_SAVED_BIT] && !(|ev[dmxdc_pkg::IRQ_BOT_SET:0]))
            state_next.top_valid = 1'b0;
        end
        dmxdc_pkg::ADDR_IRQ:  state_next.irq_stat = state_reg.irq_stat & ~pwdata[dmxdc_pkg::IRQ_W-1:0];
        dmxdc_pkg::ADDR_MASK: state_next.irq_mask = pwdata[dmxdc_pkg::IRQ_W-1:0];
        default: state_next.irq_mask = state_next.irq_mask;
      endcase
    end
    // Set beats clear
    state_next.irq_stat = state_next.irq_stat | ev;

    // APB read data captured in setup phase
    if (apb_rd)
    begin
      case (paddr)
        dmxdc_pkg::ADDR_CTRL:   state_next.prdata = {15'h0, state_reg.saved_flag, 7'h0,
                                                     state_reg.start_addr};
        dmxdc_pkg::ADDR_STATUS: state_next.prdata = {20'h0, state_reg.top_valid,
                                                     state_reg.bot_valid, run_ok,
                                                     state_reg.motor.run, state_reg.motor.dir_up,
                                                     2'h0, state_reg.fsm};
        dmxdc_pkg::ADDR_IRQ:    state_next.prdata = {28'h0, state_reg.irq_stat};
        dmxdc_pkg::ADDR_MASK:   state_next.prdata = {28'h0, state_reg.irq_mask};
        dmxdc_pkg::ADDR_CH_LO:  state_next.prdata = {chan.safety, chan.speed,
                                                     chan.pos_lo, chan.pos_hi};
        dmxdc_pkg::ADDR_CH_HI:  state_next.prdata = {16'h0, chan.man_dn, chan.man_up};
        dmxdc_pkg::ADDR_POS:    state_next.prdata = enc_count;
        dmxdc_pkg::ADDR_TOP:    state_next.prdata = state_reg.top_cnt;
        dmxdc_pkg::ADDR_BOT:    state_next.prdata = state_reg.bot_cnt;
        dmxdc_pkg::ADDR_RANGE:  state_next.prdata = state_reg.range;
        dmxdc_pkg::ADDR_SAVED:  state_next.prdata = state_reg.saved_pos;
        default:                state_next.prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_reg            <= '0;
      state_reg.fsm        <= dmxdc_pkg::ST_IDLE;
      state_reg.start_addr <= dmxdc_pkg::START_ADDR_RST;
    end
    else
      state_reg <= state_next;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign motor     = state_reg.motor;
  assign save_req  = state_reg.save_req;
  assign err_clear = state_reg.err_clear;
  assign irq       = |(state_reg.irq_stat & state_reg.irq_mask);
  assign prdata    = state_reg.prdata;
  assign pready    = 1'b1;
  assign pslverr   = 1'b0;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_run_window: assert property (@(posedge core_clk) disable iff (!rst_n)
    !run_ok |=> !motor.run)
    else $error("motor runs outside run window");

  a_stop_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
    !run_ok |=> err_clear)
    else $error("errors not cleared outside run window");

  a_brake_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_reg.fsm == dmxdc_pkg::ST_POS && chan.speed == 8'h00 |=> !motor.run)
    else $error("positioning with zero speed");

  a_speed_cap: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_reg.fsm == dmxdc_pkg::ST_POS && !man_any && run_ok && motor.run
    |-> motor.speed <= $past(chan.speed))
    else $error("positioning speed above limit");

  a_top_hard: assert property (@(posedge core_clk) disable iff (!rst_n)
    hard_top |=> !(motor.run && motor.dir_up))
    else $error("upward motion at hard top");

  a_bot_hard: assert property (@(posedge core_clk) disable iff (!rst_n)
    hard_bot |=> !(motor.run && !motor.dir_up))
    else $error("downward motion at hard bottom");

  a_man_delay: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_reg.fsm == dmxdc_pkg::ST_WAIT |-> !motor.run)
    else $error("manual motion before delay");

  a_man_speed: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_reg.fsm == dmxdc_pkg::ST_MAN && man_up && run_ok && !hard_top
    |=> motor.speed == $past(chan.man_up))
    else $error("manual up speed not tracking fader");

  a_bot_order: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(state_reg.bot_valid) |-> state_reg.top_valid)
    else $error("bottom set before top");

  a_range_calc: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(state_reg.bot_valid) |-> state_reg.range == state_reg.top_cnt - state_reg.bot_cnt)
    else $error("range mismatch");

  c_manual_up:  cover property (@(posedge core_clk) disable iff (!rst_n)
    state_reg.fsm == dmxdc_pkg::ST_MAN && motor.run && motor.dir_up);
  c_bottom_set: cover property (@(posedge core_clk) disable iff (!rst_n)
    $rose(state_reg.bot_valid));
  c_position:   cover property (@(posedge core_clk) disable iff (!rst_n)
    state_reg.fsm == dmxdc_pkg::ST_POS && motor.run);
  c_saved:      cover property (@(posedge core_clk) disable iff (!rst_n) save_req);

endmodule

// *** dmxdc_dmx_ctrl_model.sv ***
// Model of the lighting controller that streams channel levels as slots
`timescale 1ns/100ps
module dmxdc_dmx_ctrl_model
(
  input  wire logic core_clk,
  output logic       slot_valid,
  output logic [8:0] slot_num,
  output logic [7:0] slot_data
);
  initial
  begin
    slot_valid = 1'b0;
    slot_num   = 9'h000;
    slot_data  = 8'h00;
  end

  // ---------------------------------------------------------------
  // Frame sender
  // ---------------------------------------------------------------
  // Neighbour slots are sent too; idle data is inverted so a stale byte never looks valid
  task automatic send(input dmxdc_pkg::dmxdc_chan_t lv, input logic [8:0] base, input int gap);
    logic [63:0] fr;
    fr = {8'hA5, lv, 8'h5A};
    for (int i = 0; i < 8; i++)
    begin
      @(posedge core_clk);
      slot_valid <= 1'b1;
      slot_num   <= base - 9'h001 + i[8:0];
      slot_data  <= fr[63 - 8 * i -: 8];
      @(posedge core_clk);
      slot_valid <= 1'b0;
      slot_data  <= ~fr[63 - 8 * i -: 8];
      repeat (gap) @(posedge core_clk);
    end
  endtask
endmodule

// *** test_dmx_drum_position_control.sv ***
// Self-checking testbench for the drum position control block
`timescale 1ns/100ps
`define CHK(g, e) \
  begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module test_dmx_drum_position_control;
  logic                    core_clk  = 1'b0;
  logic                    rst_n     = 1'b0;
  logic                    psel      = 1'b0;
  logic                    penable   = 1'b0;
  logic                    pwrite    = 1'b0;
  logic [7:0]              paddr     = 8'h00;
  logic [31:0]             pwdata    = 32'h0;
  logic [31:0]             enc_count = 32'h0;
  logic                    hard_top  = 1'b0;
  logic                    hard_bot  = 1'b0;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    slot_valid;
  logic [8:0]              slot_num;
  logic [7:0]              slot_data;
  dmxdc_pkg::dmxdc_motor_t motor;
  logic                    save_req;
  logic                    err_clear;
  logic                    irq;
  logic [31:0]             q;
  logic [7:0]              lvl [4] = '{8'h7F, 8'h80, 8'h8C, 8'h8D};
  logic                    errx [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  int                      failures   = 0;
  int                      num_checks = 0;
  int                      saves      = 0;

  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) if (save_req === 1'b1) saves++;

  dmxdc_drum_ctrl #(.MAN_DELAY(8), .SAVE_DELAY(4)) dut_u
  (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .slot_valid(slot_valid), .slot_num(slot_num),
    .slot_data(slot_data), .enc_count(enc_count), .hard_top(hard_top),
    .hard_bot(hard_bot), .motor(motor), .save_req(save_req),
    .err_clear(err_clear), .irq(irq)
  );

  dmxdc_dmx_ctrl_model dmx_u
  (
    .core_clk(core_clk), .slot_valid(slot_valid), .slot_num(slot_num),
    .slot_data(slot_data)
  );

  // ---------------------------------------------------------------
  // Bus and frame tasks
  // ---------------------------------------------------------------
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Channels from the left: pos high, pos low, speed, safety, up, down
  task frame(input logic [47:0] lv);
    dmx_u.send(lv, 9'h00A, 0);
  endtask

  task stop_test;
    if (failures == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge core_clk);
    failures++;
    stop_test();
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(0, dmxdc_pkg::ADDR_CTRL, 32'h0);
    `CHK(q[8:0], 9'h001)
    apb(0, dmxdc_pkg::ADDR_STATUS, 32'h0);
    `CHK(q[11:10], 2'b00)
    apb(0, 8'h3C, 32'h0);
    `CHK(q, 32'h0)
    `CHK(pslverr, 1'b0)
    `CHK(err_clear, 1'b1)
    `CHK(saves, 1)
    apb(0, dmxdc_pkg::ADDR_IRQ, 32'h0);
    `CHK(q, 32'h4)
    apb(1, dmxdc_pkg::ADDR_MASK, 32'hF);
    @(negedge core_clk);
    `CHK(irq, 1'b1)
    apb(1, dmxdc_pkg::ADDR_IRQ, 32'h4);
    @(negedge core_clk);
    `CHK(irq, 1'b0)
    apb(1, dmxdc_pkg::ADDR_CTRL, 32'h1FA);
    apb(1, dmxdc_pkg::ADDR_CTRL, 32'h1FB);
    apb(0, dmxdc_pkg::ADDR_CTRL, 32'h0);
    `CHK(q[8:0], 9'h1FA)
    apb(1, dmxdc_pkg::ADDR_CTRL, 32'h00A);
    // Slow controller with channel four at zero, as before a power down
    dmx_u.send(48'h1234_4000_0000, 9'h00A, 3);
    apb(0, dmxdc_pkg::ADDR_CH_LO, 32'h0);
    `CHK(q, 32'h0040_3412)
    // Bottom fader first must not give a valid bottom
    frame(48'h1234_4080_0010);
    `CHK(motor.run, 1'b0)
    repeat (10) @(posedge core_clk);
    `CHK(motor, 10'h210)
    frame(48'h1234_4080_0000);
    apb(0, dmxdc_pkg::ADDR_STATUS, 32'h0);
    `CHK(q[10], 1'b0)
    enc_count <= 32'd1000;
    frame(48'h1234_4080_0600);
    `CHK(motor.run, 1'b0)
    repeat (10) @(posedge core_clk);
    `CHK(motor, 10'h306)
    hard_top <= 1'b1;
    repeat (3) @(posedge core_clk);
    `CHK(motor.run, 1'b0)
    frame(48'h1234_4080_0000);
    hard_top <= 1'b0;
    apb(0, dmxdc_pkg::ADDR_TOP, 32'h0);
    `CHK(q, 32'd1000)
    enc_count <= 32'd200;
    frame(48'h1234_4080_00FF);
    repeat (10) @(posedge core_clk);
    `CHK(motor, 10'h2FF)
    hard_bot <= 1'b1;
    repeat (3) @(posedge core_clk);
    `CHK(motor.run, 1'b0)
    hard_bot <= 1'b0;
    frame(48'h1234_4080_0000);
    apb(0, dmxdc_pkg::ADDR_RANGE, 32'h0);
    `CHK(q, 32'd800)
    // Target count is 200 + (800 * 0x1234 >> 16) = 256
    `CHK(motor, 10'h340)
    apb(0, dmxdc_pkg::ADDR_BOT, 32'h0);
    `CHK(q, 32'd200)
    apb(0, dmxdc_pkg::ADDR_IRQ, 32'h0);
    `CHK(q[3:0], 4'hB)
    `CHK(irq, 1'b1)
    frame(48'h1234_0080_0000);
    repeat (3) @(posedge core_clk);
    `CHK(motor.run, 1'b0)
    enc_count <= 32'd256;
    frame(48'h1234_4080_0000);
    repeat (3) @(posedge core_clk);
    `CHK(motor.run, 1'b0)
    // Bottom fader again with both limits valid: back to target on release
    frame(48'h1234_4080_0020);
    repeat (10) @(posedge core_clk);
    `CHK(motor, 10'h220)
    frame(48'h1234_4080_0000);
    repeat (2) @(posedge core_clk);
    // New span 1000 - 256 = 744, target 256 + (744 * 0x1234 >> 16) = 308
    `CHK(motor, 10'h340)
    for (int i = 0; i < 4; i++)
    begin
      frame({24'h123440, lvl[i], 16'h0000});
      `CHK(err_clear, errx[i])
    end
    repeat (8) @(posedge core_clk);
    `CHK(saves, 3)
    apb(0, dmxdc_pkg::ADDR_SAVED, 32'h0);
    `CHK(q, 32'd256)
    apb(0, dmxdc_pkg::ADDR_CTRL, 32'h0);
    `CHK(q[16], 1'b1)
    stop_test();
  end
endmodule
